// ---- passive_serial_config_port.sv ----
/*
 * passive serial configuration port: the host drives the request line, the serial clock
 * and one data line; bits are packed into words and handed out through a fifo.
 * assumes all pins are asynchronous to clock and pass two flip-flops; open-drain lines are
 * pulled high outside the block, so oe high means the line is driven low.
 */
`timescale 1ns/100ps
module passive_serial_config_port #(
	parameter int WORD_BITS = serial_config_pkg::CFG_WORD_BITS,
	parameter int WORDS = serial_config_pkg::CFG_WORDS,
	parameter int FIFO_DEPTH = serial_config_pkg::FIFO_DEPTH,
	parameter int POR_CYCLES = serial_config_pkg::POR_CYCLES,
	parameter int INIT_CYCLES = serial_config_pkg::INIT_CYCLES
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic clock_enable,
	input wire logic config_request_n,
	input wire logic serial_config_clock,
	input wire logic serial_config_data_in,
	output logic serial_config_data_out,
	output logic serial_config_data_oe,
	output logic status_n_out,
	output logic status_n_oe,
	output logic config_done_out,
	output logic config_done_oe,
	output logic init_done_out,
	output logic init_done_oe,
	output logic user_mode,
	input wire logic user_data_out,
	input wire logic user_data_oe,
	output logic user_data_in,
	output logic cfg_word_valid,
	output logic [WORD_BITS-1:0] cfg_word_data,
	input wire logic cfg_word_ready
);
	localparam int BW = $clog2(WORD_BITS + 1);
	localparam int WW = $clog2(WORDS + 1);
	localparam int TW = serial_config_pkg::TIMER_BITS;

	typedef struct packed {
		logic [1:0] req_sync;
		logic [1:0] clk_sync;
		logic [1:0] data_sync;
		logic clk_last;
		serial_config_pkg::cfg_state_t state;
		logic [TW-1:0] timer;
		logic [WORD_BITS-1:0] shift;
		logic [BW-1:0] bit_cnt;
		logic [WW-1:0] word_cnt;
		logic [1:0] fall_cnt;
		logic opt_init_done;
		logic opt_user_io;
		logic push_valid;
		logic [WORD_BITS-1:0] push_data;
	} port_state_t;

	port_state_t s_reg;
	port_state_t s_next;
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic clk_rise;
	logic clk_fall;
	logic req_low;
	logic [WORD_BITS-1:0] word_now;

	cfg_stream_if #(.WIDTH(WORD_BITS)) fill_if ();
	cfg_stream_if #(.WIDTH(WORD_BITS)) drain_if ();

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	function automatic logic [TW-1:0] to_timer(input int cycles);
		to_timer = TW'(cycles);
	endfunction : to_timer

	assign clk_rise = s_reg.clk_sync[1] && !s_reg.clk_last;
	assign clk_fall = !s_reg.clk_sync[1] && s_reg.clk_last;
	assign req_low = !s_reg.req_sync[1];
	assign word_now = {s_reg.data_sync[1], s_reg.shift[WORD_BITS-1:1]};

	always_comb begin
		s_next = s_reg;
		s_next.req_sync = {s_reg.req_sync[0], config_request_n};
		s_next.clk_sync = {s_reg.clk_sync[0], serial_config_clock};
		s_next.data_sync = {s_reg.data_sync[0], serial_config_data_in};
		s_next.clk_last = s_reg.clk_sync[1];
		if (fill_if.ready) begin
			s_next.push_valid = 1'b0;
		end
		case (s_reg.state)
			serial_config_pkg::ST_POR: begin
				s_next.timer = s_reg.timer + 1'b1;
				if (s_reg.timer >= to_timer(POR_CYCLES - 1)) begin
					s_next.state = serial_config_pkg::ST_CLEAR;
				end
			end
			serial_config_pkg::ST_CLEAR: begin
				s_next.bit_cnt = '0;
				s_next.word_cnt = '0;
				s_next.fall_cnt = '0;
				s_next.timer = '0;
				s_next.opt_init_done = 1'b0;
				s_next.opt_user_io = 1'b0;
				if (!req_low) begin
					s_next.state = serial_config_pkg::ST_LOAD;
				end
			end
			serial_config_pkg::ST_LOAD: begin
				if (clk_rise) begin
					s_next.shift = word_now;
					s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
					if (s_reg.bit_cnt == BW'(WORD_BITS - 1)) begin
						s_next.bit_cnt = '0;
						s_next.word_cnt = s_reg.word_cnt + 1'b1;
						if (s_reg.word_cnt == '0) begin
							s_next.opt_init_done = word_now[serial_config_pkg::OPTION_INIT_DONE_BIT];
							s_next.opt_user_io = word_now[serial_config_pkg::OPTION_DATA_USER_IO_BIT];
						end
						// a word lost to a full fifo is an error
						if (s_reg.push_valid && !fill_if.ready) begin
							s_next.state = serial_config_pkg::ST_ERROR;
						end else begin
							s_next.push_valid = 1'b1;
							s_next.push_data = word_now;
							// done only after the last word
							if (s_reg.word_cnt == WW'(WORDS - 1)) begin
								s_next.state = serial_config_pkg::ST_DONE_WAIT;
							end
						end
					end
				end
			end
			serial_config_pkg::ST_DONE_WAIT: begin
				if (clk_fall) begin
					s_next.fall_cnt = s_reg.fall_cnt + 1'b1;
					if (s_reg.fall_cnt == serial_config_pkg::DONE_FALL_EDGES - 2'h1) begin
						s_next.state = serial_config_pkg::ST_INIT;
					end
				end
			end
			serial_config_pkg::ST_INIT: begin
				s_next.timer = s_reg.timer + 1'b1;
				if (s_reg.timer >= to_timer(INIT_CYCLES - 1)) begin
					s_next.state = serial_config_pkg::ST_USER;
				end
			end
			serial_config_pkg::ST_USER: begin
			end
			serial_config_pkg::ST_ERROR: begin
			end
			default: begin
				s_next.state = serial_config_pkg::ST_CLEAR;
			end
		endcase
		// request low restarts configuration from any state past power-on
		if (req_low && s_reg.state != serial_config_pkg::ST_POR) begin
			s_next.state = serial_config_pkg::ST_CLEAR;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else if (clock_enable) begin
			s_reg <= s_next;
		end
	end

	assign fill_if.valid = s_reg.push_valid;
	assign fill_if.data = s_reg.push_data;
	assign cfg_word_valid = drain_if.valid;
	assign cfg_word_data = drain_if.data;
	assign drain_if.ready = cfg_word_ready;

	cfg_word_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) word_fifo (
		.clock(clock),
		.reset_n(rst_n),
		.clock_enable(clock_enable),
		.fill(fill_if.sink),
		.drain(drain_if.source)
	);

	// status low during power-on, clear and error; released otherwise
	assign status_n_out = 1'b0;
	assign status_n_oe = (s_reg.state == serial_config_pkg::ST_POR)
		|| (s_reg.state == serial_config_pkg::ST_CLEAR)
		|| (s_reg.state == serial_config_pkg::ST_ERROR);
	// done held low until every word arrived
	assign config_done_out = 1'b0;
	assign config_done_oe = (s_reg.state == serial_config_pkg::ST_POR)
		|| (s_reg.state == serial_config_pkg::ST_CLEAR)
		|| (s_reg.state == serial_config_pkg::ST_LOAD)
		|| (s_reg.state == serial_config_pkg::ST_ERROR);
	// init-done low from option load until user mode
	assign init_done_out = 1'b0;
	assign init_done_oe = s_reg.opt_init_done && (s_reg.state != serial_config_pkg::ST_USER);
	assign user_mode = (s_reg.state == serial_config_pkg::ST_USER);
	// data pin handed to user logic
	assign serial_config_data_out = user_data_out;
	assign serial_config_data_oe = user_mode && s_reg.opt_user_io && user_data_oe;
	assign user_data_in = s_reg.data_sync[1];
endmodule : passive_serial_config_port

// ---- serial_config_pkg.sv ----
/*
 * constants shared by the passive serial configuration port and its word fifo.
 * assumes a 100 MHz core clock; times are kept in ns and turned into cycle counts here.
 */
package serial_config_pkg;
	localparam int CLOCK_PERIOD_NS = 10;
	// power-on hold of the status line; plain default, a top parameter can shorten it
	localparam int POR_DELAY_NS = 100000;
	localparam int POR_CYCLES = (POR_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	// least time from configuration done to user mode (initialization)
	localparam int INIT_TIME_NS = 175000;
	localparam int INIT_CYCLES = (INIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int TIMER_BITS = 32;
	localparam logic [1:0] DONE_FALL_EDGES = 2'h2;
	localparam int CFG_WORD_BITS = 8;
	localparam int CFG_WORDS = 64;
	localparam int FIFO_DEPTH = 8;
	// the first word of the bitstream carries the option bits
	localparam int OPTION_INIT_DONE_BIT = 0;
	localparam int OPTION_DATA_USER_IO_BIT = 1;

	typedef enum logic [2:0] {
		ST_POR,
		ST_CLEAR,
		ST_LOAD,
		ST_DONE_WAIT,
		ST_INIT,
		ST_USER,
		ST_ERROR
	} cfg_state_t;
endpackage : serial_config_pkg

// ---- cfg_stream_if.sv ----
/*
 * valid/ready word stream between the configuration port and its fifo.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface cfg_stream_if #(
	parameter int WIDTH = serial_config_pkg::CFG_WORD_BITS
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface : cfg_stream_if

// ---- cfg_word_fifo.sv ----
/*
 * small word fifo with a registered read stage.
 * assumes synchronous use on one clock, reset released synchronously by the caller.
 */
`timescale 1ns/100ps
module cfg_word_fifo #(
	parameter int WIDTH = serial_config_pkg::CFG_WORD_BITS,
	parameter int DEPTH = serial_config_pkg::FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_enable,
	cfg_stream_if.sink fill,
	cfg_stream_if.source drain
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [CW-1:0] count;
		logic out_valid;
		logic [WIDTH-1:0] out_data;
	} fifo_state_t;

	fifo_state_t s_reg;
	fifo_state_t s_next;
	logic do_write;
	logic do_read;

	assign fill.ready = (s_reg.count != FULL_COUNT);
	assign drain.valid = s_reg.out_valid;
	assign drain.data = s_reg.out_data;

	always_comb begin
		s_next = s_reg;
		do_write = fill.valid && fill.ready;
		do_read = (s_reg.count != '0) && (!s_reg.out_valid || drain.ready);
		if (do_write) begin
			s_next.mem[s_reg.wr_ptr] = fill.data;
			s_next.wr_ptr = (s_reg.wr_ptr == PW'(DEPTH - 1)) ? '0 : s_reg.wr_ptr + 1'b1;
		end
		if (do_read) begin
			s_next.out_data = s_reg.mem[s_reg.rd_ptr];
			s_next.out_valid = 1'b1;
			s_next.rd_ptr = (s_reg.rd_ptr == PW'(DEPTH - 1)) ? '0 : s_reg.rd_ptr + 1'b1;
		end else if (drain.ready) begin
			s_next.out_valid = 1'b0;
		end
		if (do_write && !do_read) begin
			s_next.count = s_reg.count + 1'b1;
		end else if (!do_write && do_read) begin
			s_next.count = s_reg.count - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else if (clock_enable) begin
			s_reg <= s_next;
		end
	end
endmodule : cfg_word_fifo

// ---- serial_host.sv ----
/* host model: drives the request, serial clock and data lines of the port.
   assumes a free-running core clock that times its 160 ns serial period. */
`timescale 1ns/100ps
module serial_host (
	input wire logic clock,
	output logic config_request_n,
	output logic serial_config_clock,
	output logic serial_config_data
);
	initial begin
		config_request_n = 1'b1;
		serial_config_clock = 1'b0;
		serial_config_data = 1'b0;
	end
	task automatic half(input logic c);
		serial_config_clock <= c;
		repeat (8) @(posedge clock);
	endtask : half
	task automatic restart();
		config_request_n <= 1'b0;
		repeat (8) @(posedge clock);
		config_request_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask : restart
	// one bit per clock, lsb first
	task automatic send(input logic [7:0] opt, input int nw);
		logic [7:0] w;
		w = opt;
		for (int k = 0; k < nw; k++) begin
			w = (k == 0) ? opt : 8'(k * 37 + 1);
			for (int i = 0; i < 8; i++) begin
				serial_config_data <= w[i];
				half(1'b0);
				half(1'b1);
			end
		end
		// released data line shows the inverse of the last bit
		serial_config_data <= ~w[7];
	endtask : send
	// extra falling edges, clock then kept high
	task automatic falls(input int n);
		repeat (n) begin
			half(1'b0);
			half(1'b1);
		end
	endtask : falls
endmodule : serial_host

// ---- passive_serial_config_port_props.sv ----
/* assertions on the pin levels and word stream of the configuration port.
   assumes clock_enable drops only while the port waits for its extra falling edges. */
`timescale 1ns/100ps
module passive_serial_config_port_props #(
	parameter int WORD_BITS = 8,
	parameter int POR_CYCLES = 20,
	parameter int INIT_CYCLES = 20
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic config_request_n,
	input logic serial_config_data_out,
	input logic serial_config_data_oe,
	input logic status_n_oe,
	input logic config_done_oe,
	input logic init_done_oe,
	input logic user_mode,
	input wire logic user_data_out,
	input wire logic user_data_oe,
	input logic cfg_word_valid,
	input logic [WORD_BITS-1:0] cfg_word_data,
	input wire logic cfg_word_ready
);
	int por_cnt;
	int low_cnt;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			por_cnt <= 0;
			low_cnt <= 0;
		end else begin
			por_cnt <= (por_cnt < POR_CYCLES) ? por_cnt + 1 : por_cnt;
			low_cnt <= (config_done_oe || user_mode) ? 0 : low_cnt + 1;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	a_por_hold: assert property (por_cnt < POR_CYCLES |-> status_n_oe && config_done_oe
		&& !user_mode) else $error("lines released during power-on hold");
	a_user_lines: assert property (user_mode |-> !status_n_oe && !config_done_oe)
		else $error("status or done line low in user mode");
	a_request_exit: assert property (user_mode && !config_request_n |->
		##[1:6] (!user_mode && config_done_oe)) else $error("request did not leave user mode");
	a_done_release: assert property ($fell(config_done_oe) |-> config_request_n
		&& !status_n_oe) else $error("done released in error or restart");
	a_done_wait: assert property ($fell(config_done_oe) |=> !user_mode [*8])
		else $error("user mode without falling edges");
	a_init_time: assert property ($rose(user_mode) |-> low_cnt >= INIT_CYCLES)
		else $error("user mode before initialization time");
	a_init_pin: assert property (init_done_oe |-> !user_mode)
		else $error("init pin low in user mode");
	a_data_pin: assert property (serial_config_data_oe |-> user_mode && user_data_oe
		&& serial_config_data_out == user_data_out) else $error("data pin driven wrongly");
	a_word_hold: assert property (cfg_word_valid && !cfg_word_ready |=> cfg_word_valid
		&& $stable(cfg_word_data)) else $error("word dropped while stalled");
	c_user: cover property ($rose(user_mode));
	c_done: cover property ($fell(config_done_oe));
	c_stall: cover property (cfg_word_valid && !cfg_word_ready);
endmodule : passive_serial_config_port_props
bind passive_serial_config_port passive_serial_config_port_props #(.WORD_BITS(WORD_BITS),
	.POR_CYCLES(POR_CYCLES), .INIT_CYCLES(INIT_CYCLES)) u_props (.clock(clock),
	.resetn(resetn), .config_request_n(config_request_n),
	.serial_config_data_out(serial_config_data_out), .serial_config_data_oe(serial_config_data_oe),
	.status_n_oe(status_n_oe), .config_done_oe(config_done_oe), .init_done_oe(init_done_oe),
	.user_mode(user_mode), .user_data_out(user_data_out), .user_data_oe(user_data_oe),
	.cfg_word_valid(cfg_word_valid), .cfg_word_data(cfg_word_data),
	.cfg_word_ready(cfg_word_ready));

// ---- passive_serial_config_port_tb.sv ----
/* self-checking bench for the configuration port with a host model.
   assumes the props checker is bound; short power-on and init counts. */
`timescale 1ns/100ps
module passive_serial_config_port_tb;
	localparam int WORDS = 12;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic user_data_out = 1'b0;
	logic user_data_oe = 1'b0;
	logic cfg_word_ready = 1'b1;
	logic clock_enable = 1'b1;
	logic data_in;
	logic req_n, sclk, sdata, data_out, data_oe, st_oe, dn_oe, in_oe, umode, wvalid;
	logic [7:0] wdata;
	logic [7:0] got[$];
	int failures = 0;
	int n_compared = 0;
	always #5 clock = ~clock;
	always @(posedge clock) begin
		if (wvalid === 1'b1 && cfg_word_ready) begin
			got.push_back(wdata);
		end
	end
	serial_host u_host (.clock(clock), .config_request_n(req_n), .serial_config_clock(sclk),
		.serial_config_data(sdata));
	passive_serial_config_port #(.WORDS(WORDS), .POR_CYCLES(20), .INIT_CYCLES(20)) u_dut (
		.clock(clock), .resetn(resetn), .clock_enable(clock_enable), .config_request_n(req_n),
		.serial_config_clock(sclk), .serial_config_data_in(sdata),
		.serial_config_data_out(data_out), .serial_config_data_oe(data_oe), .status_n_out(),
		.status_n_oe(st_oe), .config_done_out(), .config_done_oe(dn_oe), .init_done_out(),
		.init_done_oe(in_oe), .user_mode(umode), .user_data_out(user_data_out),
		.user_data_oe(user_data_oe), .user_data_in(data_in), .cfg_word_valid(wvalid),
		.cfg_word_data(wdata), .cfg_word_ready(cfg_word_ready));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude
	task automatic t_por();
		repeat (18) @(posedge clock);
		check("status_oe", st_oe, 1);
		for (int i = 0; i < 60 && st_oe !== 1'b0; i++) @(posedge clock);
		check("status_end", st_oe, 0);
		check("done_oe", dn_oe, 1);
	endtask : t_por
	task automatic t_config(input logic [7:0] opt);
		u_host.restart();
		repeat (20) @(posedge clock);
		got.delete();
		u_host.send(opt, WORDS);
		check("load_done", dn_oe, 0);
		repeat (8) @(posedge clock);
		check("init_oe", in_oe, {7'h0, opt[0]});
		check("nwords", 8'(got.size()), 8'(WORDS));
		for (int k = 0; k < WORDS && k < got.size(); k++)
			check("word", got[k], (k == 0) ? opt : 8'(k * 37 + 1));
		repeat (40) @(posedge clock);
		check("early_user", umode, 0);
		// frozen port must miss these falling edges
		clock_enable <= 1'b0;
		u_host.falls(2);
		clock_enable <= 1'b1;
		repeat (40) @(posedge clock);
		check("frozen_user", umode, 0);
		check("frozen_done", dn_oe, 0);
		u_host.falls(2);
		for (int i = 0; i < 200 && umode !== 1'b1; i++) @(posedge clock);
		check("user_mode", umode, 1);
		check("user_status", st_oe, 0);
		check("user_done", dn_oe, 0);
		check("user_init", in_oe, 0);
	endtask : t_config
	task automatic t_io(input logic exp);
		user_data_oe <= 1'b1;
		user_data_out <= 1'b1;
		repeat (2) @(posedge clock);
		check("data_oe", data_oe, exp);
		check("data_out", data_out, 1);
		check("data_in", data_in, sdata);
		user_data_oe <= 1'b0;
	endtask : t_io
	task automatic t_partial();
		u_host.restart();
		check("left_user", umode, 0);
		check("done_again", dn_oe, 1);
		u_host.send(8'h01, WORDS / 2);
		u_host.falls(2);
		repeat (40) @(posedge clock);
		check("partial_done", dn_oe, 1);
		check("partial_user", umode, 0);
	endtask : t_partial
	task automatic t_overrun();
		cfg_word_ready <= 1'b0;
		u_host.restart();
		u_host.send(8'h00, WORDS);
		u_host.falls(2);
		repeat (40) @(posedge clock);
		check("overrun_status", st_oe, 1);
		check("overrun_done", dn_oe, 1);
		cfg_word_ready <= 1'b1;
		t_config(8'h00);
	endtask : t_overrun
	initial begin
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		t_por();
		t_config(8'h01);
		t_io(1'b0);
		t_partial();
		t_config(8'h02);
		t_io(1'b1);
		t_overrun();
		conclude();
	end
	initial begin
		#400000;
		failures++;
		conclude();
	end
endmodule : passive_serial_config_port_tb
